/* File: logic/mapper_regs.svh */
/*
  Constants of the configuration-register mapper and the SFR export
  mapper: register addresses, field positions, reset values and the
  upper address bytes, three of which initialization loads.
  Assumes inclusion by bare name from the package only.
*/
// Notes on behaviour
// (RULE1) Config mapper beats every other data mapper.
// (RULE2) Reset zone is 4K, F000h to FFFFh.
// (RULE3) Zone source holds address bits 15:12 only.
// (RULE4) Config mapper always on; reaches all mapper registers.
// (RULE5) Size bit set at reset: 4K, cleared 256.
// (RULE6) Init ends by clearing size bit to 256.
// (RULE7) Non-internal SFR access drives full 32-bit address.
// (RULE8) Export mapper disabled after reset until enabled.
// (RULE9) Upper byte: latch register on RMW, else pin.
// (RULE10) Address is upper, mid, low, then SFR address.
// (RULE11) Soft-module SFRs replace core SFRs, go to bus.
// (RULE12) Exported SFRs take direct and bit instructions.
// (RULE13) Each mapper puts its own upper byte out.
// (RULE14) Init loads code mapper upper byte defaults; init here loads none, as there is no code mapper.
// (RULE15) Init loads data mapper upper byte defaults; init here loads only the config data byte 98h.
// (RULE16) Init loads E0h latch and C0h pin bytes.
// (RULE17) Distinct upper bytes let breakpoints tell fetches apart.
// (RULE18) Reduced config zone sits in top 256 bytes.
// (RULE19) Match bits 15:12; 256 mode needs 11:8 ones.
`ifndef MAPPER_REGS_SVH
`define MAPPER_REGS_SVH

// ==================================================================
// Register addresses in the config zone
`define CFG_TARGET_ADDR 16'hff19
`define CFG_SOURCE_ADDR 16'hff1a
`define CFG_CONTROL_ADDR 16'hff1b
`define XP_LOW_ADDR 16'hfe20
`define XP_MID_ADDR 16'hfe21
`define XP_PIN_ADDR 16'hfe22
`define XP_ENABLE_ADDR 16'hfe23
`define XP_LATCH_ADDR 16'hfe24

// ==================================================================
// Fields and reset values
`define CFG_SIZE_BIT 0
`define XP_ENABLE_BIT 0
`define CFG_SOURCE_RST 4'hf
`define CFG_SIZE_RST 1'b1
`define CFG_TARGET_RST 8'h00
`define XP_BYTE_RST 8'h00
`define XP_ENABLE_RST 1'b0

// ==================================================================
// Upper address bytes; initialization loads only the config data, SFR latch and SFR pin bytes
`define UB_MID_CODE_OPERAND 8'h30 // RULE14
`define UB_MID_CODE_OPCODE 8'h50
`define UB_FIRST_CODE_OPERAND 8'h28
`define UB_FIRST_CODE_OPCODE 8'h48
`define UB_BOOT_CODE_OPERAND 8'h20
`define UB_BOOT_CODE_OPCODE 8'h40
`define UB_CONFIG_DATA 8'h98
`define UB_PROG5_DATA 8'ha8
`define UB_PROG4_DATA 8'ha0
`define UB_PROG2_DATA 8'h90
`define UB_PROG1_DATA 8'h88
`define UB_RAM_DATA 8'h80
`define UB_SFR_LATCH 8'he0
`define UB_SFR_PIN 8'hc0

// ==================================================================
// Controller registers on AHB-Lite (byte addresses)
`define CT_ADDR_OFS 8'h00
`define CT_WDATA_OFS 8'h04
`define CT_CMD_OFS 8'h08
`define CT_STATUS_OFS 8'h0c
`define CT_BUSADDR_OFS 8'h10
`define CT_RDATA_OFS 8'h14
`define CMD_WRITE_BIT 0
`define CMD_SFR_BIT 1
`define CMD_INTERNAL_BIT 2
`define CMD_RMW_BIT 3
`define ST_BUSY_BIT 0
`define ST_INIT_DONE_BIT 1
`define ST_ROUTE_LSB 2

`endif

/* File: logic/mapper_pkg.sv */
/*
  Types shared by the mapper link and both ends.
  Assumes the constants header sits beside it.
*/
package mapper_pkg;
  `include "mapper_regs.svh"

  // Where an access went
  typedef enum logic [1:0] {
    ROUTE_PASS,
    ROUTE_CONFIG_REG,
    ROUTE_BUS,
    ROUTE_CORE_SFR
  } route_e;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_CFG_TARGET,
    SEL_CFG_SOURCE,
    SEL_CFG_CONTROL,
    SEL_XP_LOW,
    SEL_XP_MID,
    SEL_XP_PIN,
    SEL_XP_LATCH
  } reg_sel_e;
endpackage

/* File: logic/mapper_link_if.sv */
/*
  Link between the access controller and the address mapper.
  Assumes both ends run on one clock; no clocking block.
*/
`timescale 1ns/10ps
interface mapper_link_if;
  import mapper_pkg::*;
  logic req;
  logic write;
  logic sfr;
  logic sfr_internal;
  logic rmw;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic ack;
  route_e route;
  logic [31:0] bus_addr;
  logic [7:0] rdata;

  modport mapper (
    input req, write, sfr, sfr_internal, rmw, addr, wdata,
    output ack, route, bus_addr, rdata
  );
  modport ctrl (
    output req, write, sfr, sfr_internal, rmw, addr, wdata,
    input ack, route, bus_addr, rdata
  );
endinterface // mapper_link_if

/* File: logic/cru_sfr_address_mapper.sv */
/*
  Configuration-register data mapper and SFR export mapper.
  Takes one core access per request, answers one cycle later with
  where it went, the 32-bit system bus address and read data.
  Assumes the far end never issues a request while one is open.
*/
`timescale 1ns/10ps
module cru_sfr_address_mapper
  import mapper_pkg::*;
(
  input wire logic i_core_clk, // 200 MHz system clock
  input wire logic i_rstn, // Async reset, active low
  mapper_link_if.mapper link, // Core access link
  output logic o_zone_is_4k, // Config zone size state
  output logic o_export_enabled // Export mapper state
);

  // ================================================================
  // Register state
  logic [7:0] cfg_target_reg;
  logic [3:0] cfg_source_reg;
  logic cfg_size_reg;
  logic [7:0] xp_low_reg;
  logic [7:0] xp_mid_reg;
  logic [7:0] xp_pin_reg;
  logic [7:0] xp_latch_reg;
  logic xp_enable_reg;
  logic ack_reg;
  route_e route_reg;
  logic [31:0] bus_addr_reg;
  logic [7:0] rdata_reg;

  // ================================================================
  // Decode helpers
  function automatic logic zone_hit(
    input logic [15:0] a,
    input logic [3:0] src,
    input logic big
  );
    zone_hit = (a[15:12] == src) // RULE19
      && (big || a[11:8] == 4'hf); // RULE19
  endfunction

  // Low byte only, so every mapper register stays reachable in the
  // 256-byte zone too; the export page aliases the config page.
  function automatic reg_sel_e reg_decode(input logic [7:0] ofs);
    logic [15:0] o;
    o = {8'h00, ofs};
    if (o == (`CFG_TARGET_ADDR & 16'h00ff)) begin
      reg_decode = SEL_CFG_TARGET;
    end else if (o == (`CFG_SOURCE_ADDR & 16'h00ff)) begin
      reg_decode = SEL_CFG_SOURCE;
    end else if (o == (`CFG_CONTROL_ADDR & 16'h00ff)) begin
      reg_decode = SEL_CFG_CONTROL;
    end else if (o == (`XP_LOW_ADDR & 16'h00ff)) begin
      reg_decode = SEL_XP_LOW;
    end else if (o == (`XP_MID_ADDR & 16'h00ff)) begin
      reg_decode = SEL_XP_MID;
    end else if (o == (`XP_PIN_ADDR & 16'h00ff)) begin
      reg_decode = SEL_XP_PIN;
    end else if (o == (`XP_LATCH_ADDR & 16'h00ff)) begin
      reg_decode = SEL_XP_LATCH;
    end else begin
      reg_decode = SEL_NONE;
    end
  endfunction

  function automatic logic is_enable_reg(input logic [7:0] ofs);
    is_enable_reg = {8'h00, ofs} == (`XP_ENABLE_ADDR & 16'h00ff);
  endfunction

  // ================================================================
  // Access classification
  logic cfg_hit;
  logic export_hit;
  logic cfg_wr;
  reg_sel_e sel;
  route_e route_next;
  logic [7:0] upper_byte;
  logic [31:0] bus_addr_next;
  logic [7:0] rdata_next;

  // Checked first among data mappers; no enable exists for it
  assign cfg_hit = !link.sfr // RULE4
    && zone_hit(link.addr, cfg_source_reg, cfg_size_reg); // RULE1
  // Core-implemented SFRs never leave; soft-module ones do
  assign export_hit = link.sfr && !link.sfr_internal // RULE11
    && xp_enable_reg; // RULE8
  assign sel = reg_decode(link.addr[7:0]);
  assign cfg_wr = link.req && link.write && cfg_hit;

  always_comb begin
    if (cfg_hit) begin
      route_next = (sel != SEL_NONE || is_enable_reg(link.addr[7:0]))
        ? ROUTE_CONFIG_REG : ROUTE_BUS;
    end else if (export_hit) begin
      route_next = ROUTE_BUS; // RULE7
    end else if (link.sfr) begin
      route_next = ROUTE_CORE_SFR;
    end else begin
      route_next = ROUTE_PASS;
    end
  end

  // Latch byte marks read-modify-write, which bit operations also
  // are, so a breakpoint can split the two instruction kinds.
  assign upper_byte = link.rmw ? xp_latch_reg // RULE9 RULE17 RULE12
    : xp_pin_reg; // RULE9

  always_comb begin
    if (cfg_hit) begin
      bus_addr_next = {cfg_target_reg, 8'h00, link.addr}; // RULE13
    end else if (export_hit) begin
      bus_addr_next = {upper_byte, xp_mid_reg, xp_low_reg,
        link.addr[7:0]}; // RULE10
    end else begin
      bus_addr_next = 32'h0000_0000;
    end
  end

  always_comb begin
    unique case (sel)
      SEL_CFG_TARGET: rdata_next = cfg_target_reg;
      SEL_CFG_SOURCE: rdata_next = {4'h0, cfg_source_reg};
      SEL_CFG_CONTROL: rdata_next = {7'h00, cfg_size_reg};
      SEL_XP_LOW: rdata_next = xp_low_reg;
      SEL_XP_MID: rdata_next = xp_mid_reg;
      SEL_XP_PIN: rdata_next = xp_pin_reg;
      SEL_XP_LATCH: rdata_next = xp_latch_reg;
      SEL_NONE: rdata_next = is_enable_reg(link.addr[7:0])
        ? {7'h00, xp_enable_reg} : 8'h00;
    endcase
    if (!(cfg_hit && !link.write)) begin
      rdata_next = 8'h00;
    end
  end

  // ================================================================
  // Config mapper registers
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_target_reg <= `CFG_TARGET_RST;
      cfg_source_reg <= `CFG_SOURCE_RST; // RULE2
      cfg_size_reg <= `CFG_SIZE_RST; // RULE5 RULE2
    end else if (cfg_wr) begin
      if (sel == SEL_CFG_TARGET) begin
        cfg_target_reg <= link.wdata;
      end
      if (sel == SEL_CFG_SOURCE) begin
        cfg_source_reg <= link.wdata[3:0]; // RULE3
      end
      if (sel == SEL_CFG_CONTROL) begin
        cfg_size_reg <= link.wdata[`CFG_SIZE_BIT]; // RULE5
      end
    end
  end

  // ================================================================
  // Export mapper registers
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      xp_low_reg <= `XP_BYTE_RST;
      xp_mid_reg <= `XP_BYTE_RST;
      xp_pin_reg <= `XP_BYTE_RST;
      xp_latch_reg <= `XP_BYTE_RST;
    end else if (cfg_wr) begin
      if (sel == SEL_XP_LOW) begin
        xp_low_reg <= link.wdata;
      end
      if (sel == SEL_XP_MID) begin
        xp_mid_reg <= link.wdata;
      end
      if (sel == SEL_XP_PIN) begin
        xp_pin_reg <= link.wdata;
      end
      if (sel == SEL_XP_LATCH) begin
        xp_latch_reg <= link.wdata;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      xp_enable_reg <= `XP_ENABLE_RST; // RULE8
    end else if (cfg_wr && is_enable_reg(link.addr[7:0])) begin
      xp_enable_reg <= link.wdata[`XP_ENABLE_BIT];
    end
  end

  // ================================================================
  // Answer, one cycle after the request
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= link.req;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      route_reg <= ROUTE_PASS;
      bus_addr_reg <= 32'h0000_0000;
      rdata_reg <= 8'h00;
    end else if (link.req) begin
      route_reg <= route_next;
      bus_addr_reg <= bus_addr_next;
      rdata_reg <= rdata_next;
    end
  end

  assign link.ack = ack_reg;
  assign link.route = route_reg;
  assign link.bus_addr = bus_addr_reg;
  assign link.rdata = rdata_reg;
  assign o_zone_is_4k = cfg_size_reg;
  assign o_export_enabled = xp_enable_reg;

endmodule // cru_sfr_address_mapper

/* File: logic/mapper_access_ctrl.sv */
/*
  Access controller: runs the start-up load of the mapper registers,
  then lets software issue single core accesses over AHB-Lite.
  Assumes one AHB-Lite master and single word transfers.
*/
`timescale 1ns/10ps
module mapper_access_ctrl
  import mapper_pkg::*;
(
  input wire logic i_core_clk, // 200 MHz system clock
  input wire logic i_rstn, // Async reset, active low
  mapper_link_if.ctrl link, // Core access link
  input wire logic i_hsel, // AHB slave select
  input wire logic [31:0] i_haddr, // AHB address
  input wire logic [1:0] i_htrans, // AHB transfer type
  input wire logic i_hwrite, // AHB write
  input wire logic [2:0] i_hsize, // AHB size, word only
  input wire logic [31:0] i_hwdata, // AHB write data
  input wire logic i_hready, // AHB bus ready
  output logic [31:0] o_hrdata, // AHB read data
  output logic o_hreadyout, // AHB slave ready
  output logic o_hresp // AHB response
);

  typedef enum logic [1:0] {
    ST_ISSUE,
    ST_WAIT,
    ST_IDLE
  } state_e;

  // ================================================================
  // State
  state_e state_reg;
  logic init_reg;
  logic [2:0] step_reg;
  logic req_reg;
  logic write_reg;
  logic sfr_reg;
  logic internal_reg;
  logic rmw_reg;
  logic [15:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [31:0] res_addr_reg;
  logic [7:0] res_data_reg;
  route_e res_route_reg;
  logic dph_wr_reg;
  logic [7:0] dph_ofs_reg;
  logic [31:0] hrdata_reg;

  // Start-up load; export enable follows the latch and pin bytes so no access is sent
  // out with half-loaded bytes; clearing the size bit comes last.
  function automatic logic [23:0] init_step(input logic [2:0] n);
    unique case (n)
      3'h0: init_step = {`CFG_TARGET_ADDR, `UB_CONFIG_DATA}; // RULE15
      3'h1: init_step = {`XP_LATCH_ADDR, `UB_SFR_LATCH}; // RULE16
      3'h2: init_step = {`XP_PIN_ADDR, `UB_SFR_PIN}; // RULE16
      3'h3: init_step = {`XP_ENABLE_ADDR, 8'h01};
      default: init_step = {`CFG_CONTROL_ADDR, 8'h00}; // RULE6 RULE18
    endcase
  endfunction

  // ================================================================
  // AHB-Lite slave, zero wait states
  logic aph;
  logic cmd_go;
  assign aph = i_hsel && i_htrans[1] && i_hready;
  assign cmd_go = dph_wr_reg && dph_ofs_reg == `CT_CMD_OFS
    && state_reg == ST_IDLE;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dph_wr_reg <= 1'b0;
      dph_ofs_reg <= 8'h00;
    end else if (i_hready) begin
      dph_wr_reg <= aph && i_hwrite;
      dph_ofs_reg <= i_haddr[7:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (aph && !i_hwrite) begin
      unique case (i_haddr[7:0])
        `CT_ADDR_OFS: hrdata_reg <= {16'h0000, addr_reg};
        `CT_WDATA_OFS: hrdata_reg <= {24'h000000, wdata_reg};
        `CT_STATUS_OFS: hrdata_reg <= {28'h0000000, res_route_reg,
          init_reg, state_reg != ST_IDLE};
        `CT_BUSADDR_OFS: hrdata_reg <= res_addr_reg;
        `CT_RDATA_OFS: hrdata_reg <= {24'h000000, res_data_reg};
        default: hrdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign o_hrdata = hrdata_reg;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  // ================================================================
  // Request fields: loaded by init steps or by software
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      addr_reg <= 16'h0000;
      wdata_reg <= 8'h00;
      write_reg <= 1'b0;
      sfr_reg <= 1'b0;
      internal_reg <= 1'b0;
      rmw_reg <= 1'b0;
    end else if (!init_reg && state_reg == ST_ISSUE) begin
      {addr_reg, wdata_reg} <= init_step(step_reg);
      write_reg <= 1'b1;
      sfr_reg <= 1'b0;
    end else if (dph_wr_reg && state_reg == ST_IDLE) begin
      if (dph_ofs_reg == `CT_ADDR_OFS) begin
        addr_reg <= i_hwdata[15:0];
      end
      if (dph_ofs_reg == `CT_WDATA_OFS) begin
        wdata_reg <= i_hwdata[7:0];
      end
      if (cmd_go) begin
        write_reg <= i_hwdata[`CMD_WRITE_BIT];
        sfr_reg <= i_hwdata[`CMD_SFR_BIT];
        internal_reg <= i_hwdata[`CMD_INTERNAL_BIT];
        rmw_reg <= i_hwdata[`CMD_RMW_BIT];
      end
    end
  end

  // ================================================================
  // Sequencer
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= ST_ISSUE;
      init_reg <= 1'b0;
      step_reg <= 3'h0;
      req_reg <= 1'b0;
    end else begin
      req_reg <= 1'b0;
      unique case (state_reg)
        ST_ISSUE: begin
          req_reg <= 1'b1;
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          if (link.ack) begin
            if (!init_reg && step_reg != 3'h4) begin
              step_reg <= step_reg + 3'h1;
              state_reg <= ST_ISSUE;
            end else begin
              init_reg <= 1'b1;
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_IDLE: begin
          if (cmd_go) begin
            state_reg <= ST_ISSUE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      res_addr_reg <= 32'h0000_0000;
      res_data_reg <= 8'h00;
      res_route_reg <= ROUTE_PASS;
    end else if (link.ack) begin
      res_addr_reg <= link.bus_addr;
      res_data_reg <= link.rdata;
      res_route_reg <= link.route;
    end
  end

  assign link.req = req_reg;
  assign link.write = write_reg;
  assign link.sfr = sfr_reg;
  assign link.sfr_internal = internal_reg;
  assign link.rmw = rmw_reg;
  assign link.addr = addr_reg;
  assign link.wdata = wdata_reg;

endmodule // mapper_access_ctrl

/* File: tb/mapper_link_monitor.sv */
/*
  Checker on the link between access controller and address mapper.
  Assumes it is instantiated beside the link and fed its signals.
*/
`timescale 1ns/10ps
module mapper_link_monitor
  import mapper_pkg::*;
(
  input wire logic i_core_clk, // System clock
  input wire logic i_rstn, // Async reset, active low
  input wire logic req, // Access request
  input wire logic write, // Write access
  input wire logic sfr, // SFR space
  input wire logic sfr_internal, // Core SFR
  input wire logic rmw, // Latch kind
  input wire logic [15:0] addr, // Logical address
  input wire logic [7:0] wdata, // Write data
  input wire logic ack, // Answer
  input wire route_e route, // Where it went
  input wire logic [31:0] bus_addr, // System bus address
  input wire logic [7:0] rdata // Read data
);
  // ================================================================
  // Shadow of the mapper registers, fed only by answered writes
  logic p_wr;
  logic [7:0] p_ofs;
  logic [7:0] p_d;
  logic [3:0] src_reg;
  logic big_reg;
  logic en_reg;
  logic [7:0] tgt_reg;
  logic [7:0] low_reg;
  logic [7:0] mid_reg;
  logic [7:0] pin_reg;
  logic [7:0] latch_reg;
  logic hit;

  assign hit = (addr[15:12] == src_reg) && (big_reg || addr[11:8] == 4'hf);

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      p_wr <= 1'b0;
      p_ofs <= 8'h00;
      p_d <= 8'h00;
    end else if (req) begin
      p_wr <= write && !sfr;
      p_ofs <= addr[7:0];
      p_d <= wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      src_reg <= 4'hf;
      big_reg <= 1'b1;
      en_reg <= 1'b0;
      tgt_reg <= 8'h00;
      low_reg <= 8'h00;
      mid_reg <= 8'h00;
      pin_reg <= 8'h00;
      latch_reg <= 8'h00;
    end else if (ack && p_wr && route == ROUTE_CONFIG_REG) begin
      case (p_ofs)
        8'h19: tgt_reg <= p_d;
        8'h1a: src_reg <= p_d[3:0];
        8'h1b: big_reg <= p_d[0];
        8'h20: low_reg <= p_d;
        8'h21: mid_reg <= p_d;
        8'h22: pin_reg <= p_d;
        8'h23: en_reg <= p_d[0];
        8'h24: latch_reg <= p_d;
        default: ;
      endcase
    end
  end

  // ================================================================
  // Properties
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  a_ack_next: assert property (req |=> ack)
    else $error("request not answered one cycle later");
  a_ack_cause: assert property (ack |-> $past(req))
    else $error("answer without a request");
  a_result_hold: assert property (!req |=> $stable(route) &&
    $stable(bus_addr) && $stable(rdata))
    else $error("result changed without a request");
  a_zone_match: assert property (req && !sfr |=>
    (route != ROUTE_PASS) == $past(hit))
    else $error("config zone match wrong");
  a_export_addr: assert property (req && sfr && !sfr_internal && en_reg
    |=> route == ROUTE_BUS && bus_addr ==
    {($past(rmw) ? latch_reg : pin_reg), mid_reg, low_reg, p_ofs})
    else $error("exported SFR bus address wrong");
  a_core_sfr_stays: assert property (req && sfr &&
    (sfr_internal || !en_reg) |=> route == ROUTE_CORE_SFR &&
    bus_addr == 32'h0)
    else $error("SFR access left the core wrongly");
  a_config_addr: assert property (req && !sfr ##1
    route == ROUTE_CONFIG_REG |-> bus_addr == {tgt_reg, 8'h00, $past(addr)})
    else $error("config hit bus address wrong");
  a_rdata_quiet: assert property (ack &&
    (route != ROUTE_CONFIG_REG || $past(write)) |-> rdata == 8'h00)
    else $error("read data not zero");
endmodule // mapper_link_monitor

/* File: tb/test_cru_sfr_address_mapper.sv */
/*
  Bench for the address mapper and its access controller.
  Assumes the design files and the link monitor compile first.
*/
`timescale 1ns/10ps
module test_cru_sfr_address_mapper;
  import mapper_pkg::*;
  logic clk;
  logic rstn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hready;
  logic zone_4k;
  logic xp_on;
  logic [31:0] res_route;
  logic [31:0] res_ba;
  logic [31:0] res_rd;
  logic [31:0] r;
  int fail_count;
  int tests_run;
  int cycles;
  logic [15:0] ta [8] = '{16'hff19, 16'hff24, 16'hff22, 16'hff1b,
                          16'hff1a, 16'hfe24, 16'hf000, 16'hff30};
  logic [1:0] tr [8] = '{2'd1, 2'd1, 2'd1, 2'd1, 2'd1, 2'd0, 2'd0, 2'd2};
  logic [7:0] td [8] = '{8'h98, 8'he0, 8'hc0, 8'h00, 8'h0f, 8'h00,
                         8'h00, 8'h00};

  mapper_link_if link ();
  cru_sfr_address_mapper cru_sfr_address_mapper_i (.i_core_clk(clk),
    .i_rstn(rstn), .link(link), .o_zone_is_4k(zone_4k),
    .o_export_enabled(xp_on));
  mapper_access_ctrl mapper_access_ctrl_i (.i_core_clk(clk),
    .i_rstn(rstn), .link(link), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp());
  mapper_link_monitor mapper_link_monitor_i (.i_core_clk(clk),
    .i_rstn(rstn), .req(link.req), .write(link.write), .sfr(link.sfr),
    .sfr_internal(link.sfr_internal), .rmw(link.rmw), .addr(link.addr),
    .wdata(link.wdata), .ack(link.ack), .route(link.route),
    .bus_addr(link.bus_addr), .rdata(link.rdata));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ================================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask

  // Command bits: rmw, internal, sfr, write
  task automatic core(input logic [3:0] cmd, input logic [15:0] a,
                      input logic [7:0] d);
    logic [31:0] q;
    ahb(1'b1, 8'h00, {16'h0, a}, q);
    ahb(1'b1, 8'h04, {24'h0, d}, q);
    ahb(1'b1, 8'h08, {28'h0, cmd}, q);
    // Status taken right after the command's data phase is still stale
    ahb(1'b0, 8'h0c, 32'h0, q);
    q = 32'h1;
    while (q[0] !== 1'b0) begin
      ahb(1'b0, 8'h0c, 32'h0, q);
    end
    res_route = {30'h0, q[3:2]};
    ahb(1'b0, 8'h10, 32'h0, res_ba);
    ahb(1'b0, 8'h14, 32'h0, q);
    res_rd = {24'h0, q[7:0]};
  endtask

  // Roughly 20 commands of about 16 cycles each
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      close_out();
    end
  end

  // ================================================================
  // Tests
  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    fail_count = 0;
    tests_run = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    check({31'h0, zone_4k}, 32'h1);
    check({31'h0, xp_on}, 32'h0);
    rstn <= 1'b1;
    $display("test reset done");
    r = 32'h0;
    while (r[1] !== 1'b1) begin
      ahb(1'b0, 8'h0c, 32'h0, r);
    end
    check({30'h0, r[1:0]}, 32'h2);
    check({31'h0, zone_4k}, 32'h0);
    check({31'h0, xp_on}, 32'h1);
    ahb(1'b0, 8'h10, 32'h0, r);
    check(r, 32'h9800ff1b);
    $display("test start-up done");
    for (int i = 0; i < 8; i++) begin
      core(4'h0, ta[i], 8'h00);
      check(res_route, {30'h0, tr[i]});
      check(res_rd, {24'h0, td[i]});
      if (tr[i] == 2'd1) check(res_ba, {8'h98, 8'h00, ta[i]});
    end
    $display("test defaults done");
    core(4'h1, 16'hff20, 8'h12);
    core(4'h1, 16'hff21, 8'h34);
    core(4'hb, 16'h0099, 8'h5a);
    check(res_route, 32'h2);
    check(res_ba, 32'he0341299);
    core(4'h2, 16'h00a8, 8'h00);
    check(res_ba, 32'hc03412a8);
    core(4'h6, 16'h0090, 8'h00);
    check(res_route, 32'h3);
    check(res_ba, 32'h0);
    $display("test export done");
    core(4'h1, 16'hff23, 8'h00);
    check({31'h0, xp_on}, 32'h0);
    core(4'h2, 16'h0099, 8'h00);
    check(res_route, 32'h3);
    $display("test disable done");
    core(4'h1, 16'hff1b, 8'h01);
    check({31'h0, zone_4k}, 32'h1);
    core(4'h0, 16'hf100, 8'h00);
    check(res_route, 32'h2);
    core(4'h1, 16'hff1a, 8'hfe);
    core(4'h0, 16'he01a, 8'h00);
    check(res_rd, 32'h0e);
    check(res_ba, 32'h9800e01a);
    core(4'h0, 16'hff19, 8'h00);
    check(res_route, 32'h0);
    $display("test zone done");
    close_out();
  end
endmodule // test_cru_sfr_address_mapper
